//--- include/uhis_pkg.sv
// How it works
// - Seven-bit target address, firmware written
// - Enable one passes interrupt, zero blocks
// - VBUS threshold edges, otg port, first host
// - OTG ID edges, otg port, first host
// - Bit 9 gates frame timer expiry
// - Bits 7,6 gate port B/A wakeup
// - Bits 5,4 gate B/A connect change
// - Bit 0 gates shared transfer done
// - Write one clears flag, zero keeps
// - Status reachable from both access ports
// - Status bit 15 latches VBUS edge
// - Status bit 14 latches ID edge
// - Status bit 9 set on timer expiry
// - Status bit 7 set on B wakeup
// - Status bit 6 set on A wakeup
// - Bits 5,4 set on SE0 edges
// - Bits 3,2 show live SE0 state
// - Status bit 0 latches transfer done
package uhis_pkg;

    localparam int unsigned HOSTS = 2;
    localparam int unsigned ADR_W = 7;

    // Register byte addresses
    localparam logic [15:0] A_H1_ADR = 16'hc088;
    localparam logic [15:0] A_H1_EN = 16'hc08c;
    localparam logic [15:0] A_H1_FLG = 16'hc090;
    localparam logic [15:0] A_H2_ADR = 16'hc0a8;
    localparam logic [15:0] A_H2_EN = 16'hc0ac;
    localparam logic [15:0] A_H2_FLG = 16'hc0b0;

    // Bit positions shared by enable and status words
    localparam int unsigned B_VBUS = 15;
    localparam int unsigned B_ID = 14;
    localparam int unsigned B_SOF = 9;
    localparam int unsigned B_WAKE_B = 7;
    localparam int unsigned B_WAKE_A = 6;
    localparam int unsigned B_CONN_B = 5;
    localparam int unsigned B_CONN_A = 4;
    localparam int unsigned B_SE0_B = 3;
    localparam int unsigned B_SE0_A = 2;
    localparam int unsigned B_DONE = 0;

    // Implemented bits; second host lacks the OTG pair
    localparam logic [15:0] M_H1 = 16'hc2f1;
    localparam logic [15:0] M_H2 = 16'h02f1;

    // Reset values
    localparam logic [15:0] EN_RST = 16'h0000;
    localparam logic [15:0] FLG_RST = 16'h0000;
    localparam logic [ADR_W-1:0] ADR_RST = 7'h00;
    localparam logic [15:0] RD_ZERO = 16'h0000;

    typedef logic [15:0] uhis_word_t;

    // One register access port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        uhis_word_t wdata;
    } uhis_bus_s;

    // Engine signals for one host instance
    typedef struct packed {
        logic done;
        logic sof_expire;
        logic wake_a;
        logic wake_b;
        logic se0_a;
        logic se0_b;
        logic vbus_hi;
        logic otg_id;
    } uhis_evt_s;

    // Access that hits one register
    function automatic logic uhis_hit(uhis_bus_s b, logic [15:0] a);
        return b.addr == a;
    endfunction

endpackage

//--- design/uhis_edge.sv
`timescale 1ns/1ps
// Either-edge detector over a group of levels
module uhis_edge #(
    parameter int unsigned W = 8
) (
    input wire logic mclk, // System clock
    input wire logic rst_n_s, // Synchronised reset, active low
    input wire logic [W-1:0] lvl, // Levels to watch
    output logic [W-1:0] edge_p // One-cycle pulse per change
);
    import uhis_pkg::*;

    logic [W-1:0] prev_q;

    // Last sample of each level
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            prev_q <= '0;
        end else begin
            prev_q <= lvl;
        end
    end

    // Rising and falling both count
    assign edge_p = lvl ^ prev_q;

    ////////////////////////////////////////////////////////////////////////
    a_edge_pulse: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $changed(lvl) |-> (edge_p != '0))
        else $error("level change gave no edge pulse");

endmodule // uhis_edge

//--- design/uhis_host_irq.sv
`timescale 1ns/1ps
// Host interrupt flags, enables and target address for two hosts
module uhis_host_irq (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst_n, // Async reset, active low
    input wire uhis_pkg::uhis_bus_s cpu_bus, // Internal processor port
    output uhis_pkg::uhis_word_t cpu_rdata, // Read data, one cycle late
    input wire uhis_pkg::uhis_bus_s hpi_bus, // Parallel host port
    output uhis_pkg::uhis_word_t hpi_rdata, // Read data, one cycle late
    input wire uhis_pkg::uhis_evt_s h1_evt, // First host engine signals
    input wire uhis_pkg::uhis_evt_s h2_evt, // Second host engine signals
    output logic irq_host1, // First host interrupt, high
    output logic irq_host2, // Second host interrupt, high
    output logic [6:0] h1_dev_addr, // First host target address
    output logic [6:0] h2_dev_addr // Second host target address
);
    import uhis_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_q;
    logic rst_n_s;

    // Two stages so release is clean against mclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_s <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    uhis_evt_s evt [HOSTS];
    logic [15:0] mask [HOSTS];
    logic [15:0] a_en [HOSTS];
    logic [15:0] a_flg [HOSTS];
    logic [15:0] a_adr [HOSTS];
    uhis_word_t en_q [HOSTS];
    uhis_word_t flags_q [HOSTS];
    uhis_word_t flags_d [HOSTS];
    uhis_word_t set_v [HOSTS];
    uhis_word_t clr_v [HOSTS];
    uhis_word_t stat_v [HOSTS];
    logic [ADR_W-1:0] adr_q [HOSTS];
    logic [HOSTS-1:0] irq_q;
    logic [7:0] lvl;
    logic [7:0] edg;

    // Per-host constants as arrays so loops can index them
    assign evt[0] = h1_evt;
    assign evt[1] = h2_evt;
    assign mask[0] = M_H1;
    assign mask[1] = M_H2;
    assign a_en[0] = A_H1_EN;
    assign a_en[1] = A_H2_EN;
    assign a_flg[0] = A_H1_FLG;
    assign a_flg[1] = A_H2_FLG;
    assign a_adr[0] = A_H1_ADR;
    assign a_adr[1] = A_H2_ADR;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection of the watched levels
    assign lvl = {h2_evt.se0_b, h2_evt.se0_a, h2_evt.otg_id,
                  h2_evt.vbus_hi, h1_evt.se0_b, h1_evt.se0_a,
                  h1_evt.otg_id, h1_evt.vbus_hi};

    uhis_edge #(
        .W(8)
    ) u_edge (
        .mclk(mclk),
        .rst_n_s(rst_n_s),
        .lvl(lvl),
        .edge_p(edg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Events per host; OTG bits drop out through the mask on host two
    always_comb begin
        for (int h = 0; h < HOSTS; h++) begin
            set_v[h] = '0;
            set_v[h][B_DONE] = evt[h].done;
            set_v[h][B_CONN_A] = edg[4*h+2];
            set_v[h][B_CONN_B] = edg[4*h+3];
            set_v[h][B_WAKE_A] = evt[h].wake_a;
            set_v[h][B_WAKE_B] = evt[h].wake_b;
            set_v[h][B_SOF] = evt[h].sof_expire;
            set_v[h][B_ID] = edg[4*h+1];
            set_v[h][B_VBUS] = edg[4*h];
            set_v[h] = set_v[h] & mask[h];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear requests from either port are merged
    always_comb begin
        for (int h = 0; h < HOSTS; h++) begin
            clr_v[h] = '0;
            if (cpu_bus.wr && uhis_hit(cpu_bus, a_flg[h])) begin
                clr_v[h] = clr_v[h] | cpu_bus.wdata;
            end
            if (hpi_bus.wr && uhis_hit(hpi_bus, a_flg[h])) begin
                clr_v[h] = clr_v[h] | hpi_bus.wdata;
            end
        end
    end

    // Set beats clear so an event in the clear cycle survives
    always_comb begin
        for (int h = 0; h < HOSTS; h++) begin
            flags_d[h] = ((flags_q[h] & ~clr_v[h]) | set_v[h]) & mask[h];
        end
    end

    // Sticky flags
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int h = 0; h < HOSTS; h++) begin
                flags_q[h] <= FLG_RST;
            end
        end else begin
            for (int h = 0; h < HOSTS; h++) begin
                flags_q[h] <= flags_d[h];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable registers; processor port wins a same-cycle collision
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int h = 0; h < HOSTS; h++) begin
                en_q[h] <= EN_RST;
            end
        end else begin
            for (int h = 0; h < HOSTS; h++) begin
                if (cpu_bus.wr && uhis_hit(cpu_bus, a_en[h])) begin
                    en_q[h] <= cpu_bus.wdata & mask[h];
                end else if (hpi_bus.wr && uhis_hit(hpi_bus, a_en[h])) begin
                    en_q[h] <= hpi_bus.wdata & mask[h];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target address, write only; only the low seven bits are kept
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int h = 0; h < HOSTS; h++) begin
                adr_q[h] <= ADR_RST;
            end
        end else begin
            for (int h = 0; h < HOSTS; h++) begin
                if (cpu_bus.wr && uhis_hit(cpu_bus, a_adr[h])) begin
                    adr_q[h] <= cpu_bus.wdata[ADR_W-1:0];
                end else if (hpi_bus.wr && uhis_hit(hpi_bus, a_adr[h])) begin
                    adr_q[h] <= hpi_bus.wdata[ADR_W-1:0];
                end
            end
        end
    end

    assign h1_dev_addr = adr_q[0];
    assign h2_dev_addr = adr_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request; registered so the pin never glitches
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_q <= '0;
        end else begin
            for (int h = 0; h < HOSTS; h++) begin
                irq_q[h] <= |(flags_q[h] & en_q[h]);
            end
        end
    end

    assign irq_host1 = irq_q[0];
    assign irq_host2 = irq_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Status word seen by reads: latched flags plus live SE0 levels
    always_comb begin
        for (int h = 0; h < HOSTS; h++) begin
            stat_v[h] = flags_q[h];
            stat_v[h][B_SE0_A] = evt[h].se0_a;
            stat_v[h][B_SE0_B] = evt[h].se0_b;
        end
    end

    // Read decode shared by both ports; address register reads zero
    function automatic uhis_word_t rd_word(logic [15:0] a,
                                            uhis_word_t s0,
                                            uhis_word_t s1,
                                            uhis_word_t e0,
                                            uhis_word_t e1);
        uhis_word_t r;
        r = RD_ZERO;
        case (a)
            A_H1_EN: r = e0;
            A_H1_FLG: r = s0;
            A_H2_EN: r = e1;
            A_H2_FLG: r = s1;
            default: r = RD_ZERO;
        endcase
        return r;
    endfunction

    // Processor read data
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cpu_rdata <= RD_ZERO;
        end else if (cpu_bus.rd) begin
            cpu_rdata <= rd_word(cpu_bus.addr, stat_v[0], stat_v[1],
                                 en_q[0], en_q[1]);
        end
    end

    // Host port read data, same map as the processor sees
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            hpi_rdata <= RD_ZERO;
        end else if (hpi_bus.rd) begin
            hpi_rdata <= rd_word(hpi_bus.addr, stat_v[0], stat_v[1],
                                 en_q[0], en_q[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Target address loads and stays hidden from reads
    a_addr_load: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        cpu_bus.wr && cpu_bus.addr == A_H1_ADR
        |=> h1_dev_addr == $past(cpu_bus.wdata[ADR_W-1:0]))
        else $error("target address not loaded");

    a_addr_cpu_wins: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        cpu_bus.wr && cpu_bus.addr == A_H2_ADR
        |=> h2_dev_addr == $past(cpu_bus.wdata[ADR_W-1:0]))
        else $error("processor address write lost");

    a_addr_read_zero: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        cpu_bus.rd && cpu_bus.addr == A_H1_ADR |=> cpu_rdata == RD_ZERO)
        else $error("write only address register read back");

    // Enables gate the request, one cycle behind the flags
    a_irq_gate: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        ##1 irq_host1 == $past(|(flags_q[0] & en_q[0])))
        else $error("host one interrupt not gated by enables");

    a_sof_gate: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.sof_expire ##1 en_q[0][B_SOF]
        |=> irq_host1)
        else $error("timer expiry gave no interrupt");

    a_wake_gate: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.wake_a ##1 en_q[0][B_WAKE_A]
        |=> irq_host1)
        else $error("port A wakeup gave no interrupt");

    a_conn_gate: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $changed(h1_evt.se0_b) ##1 en_q[0][B_CONN_B]
        |=> irq_host1)
        else $error("port B connect change gave no interrupt");

    a_done_set: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.done ##1 en_q[0][B_DONE]
        |=> irq_host1)
        else $error("transfer done gave no interrupt");

    a_irq_cause: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $rose(irq_host2)
        |-> $past(|(flags_q[1] & en_q[1])))
        else $error("host two interrupt without cause");

    // Events latch whatever the enables say
    a_vbus_edge: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $changed(h1_evt.vbus_hi) |=> flags_q[0][B_VBUS])
        else $error("VBUS edge not latched");

    a_id_edge: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $changed(h1_evt.otg_id) |=> flags_q[0][B_ID])
        else $error("ID edge not latched");

    a_h2_reserved: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        flags_q[1][B_VBUS] == 1'b0 && flags_q[1][B_ID] == 1'b0)
        else $error("second host OTG bits set");

    a_sof_expiry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.sof_expire |=> flags_q[0][B_SOF])
        else $error("timer expiry not latched");

    a_wake_b_set: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.wake_b |=> flags_q[0][B_WAKE_B])
        else $error("port B wakeup not latched");

    a_conn_set: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        $changed(h1_evt.se0_a) |=> flags_q[0][B_CONN_A])
        else $error("connect change not latched");

    a_se0_live: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        cpu_bus.rd && cpu_bus.addr == A_H1_FLG
        |=> cpu_rdata[B_SE0_A] == $past(h1_evt.se0_a)
            && cpu_rdata[B_SE0_B] == $past(h1_evt.se0_b))
        else $error("SE0 status not live");

    a_done_latch: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.done |=> flags_q[0][B_DONE])
        else $error("transfer done not latched");

    // Clearing from either port
    a_w1c_keep: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        flags_q[0][B_SOF] && clr_v[0][B_SOF] == 1'b0
        |=> flags_q[0][B_SOF])
        else $error("flag lost without a one written");

    a_set_wins: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        h1_evt.sof_expire && clr_v[0][B_SOF] |=> flags_q[0][B_SOF])
        else $error("clear beat a same-cycle event");

    a_hpi_clear: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        hpi_bus.wr && hpi_bus.addr == A_H1_FLG && hpi_bus.wdata[B_DONE]
        && !h1_evt.done |=> !flags_q[0][B_DONE])
        else $error("host port write did not clear flag");

endmodule // uhis_host_irq

//--- tb/uhis_port_model.sv
`timescale 1ns/1ps
// Devices on ports A and B as seen by the line-state and wake detectors
module uhis_port_model (
    input wire logic [1:0] attach, // Device present, bit 1 port B
    input wire logic [1:0] wake_cmd, // Remote wakeup pulse request
    output uhis_pkg::uhis_evt_s dev // Line and wake signals
);
    import uhis_pkg::*;

    // Empty port sits in SE0, an attached device pulls to J
    always_comb begin
        dev = '0;
        dev.se0_a = ~attach[0];
        dev.se0_b = ~attach[1];
        dev.wake_a = wake_cmd[0];
        dev.wake_b = wake_cmd[1];
    end
endmodule // uhis_port_model

//--- tb/usb_host_interrupt_status_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    fails++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module usb_host_interrupt_status_test;
    import uhis_pkg::*;

    typedef struct packed {
        logic [7:0] eng;
        logic [1:0] att;
        logic [1:0] wk;
        uhis_word_t exp;
    } uhis_row_s;

    logic mclk;
    logic rst_n;
    uhis_bus_s cpu_bus;
    uhis_bus_s hpi_bus;
    uhis_word_t cpu_rdata;
    uhis_word_t hpi_rdata;
    logic [7:0] eng1;
    logic [7:0] eng2;
    logic [1:0] attach;
    logic [1:0] wake_cmd;
    uhis_evt_s dev1;
    uhis_evt_s h1_evt;
    uhis_evt_s h2_evt;
    logic irq_host1;
    logic irq_host2;
    logic [6:0] h1_dev_addr;
    logic [6:0] h2_dev_addr;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    uhis_row_s rows [9];

    // Engine pulses from the bench; host one's are merged with the device line model
    assign h1_evt = uhis_evt_s'(eng1 | dev1);
    assign h2_evt = uhis_evt_s'(eng2);

    uhis_port_model uhis_port_model_inst (
        .attach(attach), .wake_cmd(wake_cmd), .dev(dev1));

    uhis_host_irq uhis_host_irq_inst (
        .mclk(mclk), .rst_n(rst_n), .cpu_bus(cpu_bus),
        .cpu_rdata(cpu_rdata), .hpi_bus(hpi_bus), .hpi_rdata(hpi_rdata),
        .h1_evt(h1_evt), .h2_evt(h2_evt), .irq_host1(irq_host1),
        .irq_host2(irq_host2), .h1_dev_addr(h1_dev_addr),
        .h2_dev_addr(h2_dev_addr));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic wrap_up;
        if (fails == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, tests need well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One access held for a single taken edge, then one idle edge
    task automatic wr(input bit p, input logic [15:0] a, input uhis_word_t d);
        uhis_bus_s b;
        b = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        if (p) hpi_bus <= b;
        else cpu_bus <= b;
        @(posedge mclk);
        cpu_bus <= '0;
        hpi_bus <= '0;
        @(posedge mclk);
    endtask

    // Read data lands at the taken edge and holds, so sample one edge on
    task automatic rd(input bit p, input logic [15:0] a, output uhis_word_t q);
        uhis_bus_s b;
        b = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        if (p) hpi_bus <= b;
        else cpu_bus <= b;
        @(posedge mclk);
        cpu_bus <= '0;
        hpi_bus <= '0;
        @(posedge mclk);
        q = p ? hpi_rdata : cpu_rdata;
    endtask

    task automatic pulse(input logic [7:0] e1, input logic [7:0] e2,
                         input logic [1:0] wk);
        eng1 <= e1;
        eng2 <= e2;
        wake_cmd <= wk;
        @(posedge mclk);
        eng1 <= 8'h00;
        eng2 <= 8'h00;
        wake_cmd <= 2'b00;
        @(posedge mclk);
    endtask

    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        uhis_word_t q;
        cpu_bus = '0;
        hpi_bus = '0;
        eng1 = 8'h00;
        eng2 = 8'h00;
        attach = 2'b11;
        wake_cmd = 2'b00;
        rst_n = 1'b0;
        // Struct order done,sof,wake_a,wake_b,se0_a,se0_b,vbus,id
        rows[0] = '{8'h80, 2'b11, 2'b00, 16'h0001};
        rows[1] = '{8'h40, 2'b11, 2'b00, 16'h0200};
        rows[2] = '{8'h00, 2'b11, 2'b01, 16'h0040};
        rows[3] = '{8'h00, 2'b11, 2'b10, 16'h0080};
        rows[4] = '{8'h02, 2'b11, 2'b00, 16'h8000};
        rows[5] = '{8'h01, 2'b11, 2'b00, 16'h4000};
        rows[6] = '{8'h00, 2'b10, 2'b00, 16'h0014};
        rows[7] = '{8'h00, 2'b00, 2'b00, 16'h002c};
        rows[8] = '{8'h00, 2'b11, 2'b00, 16'h0030};
        @(posedge mclk);
        reset_dut();
        rd(0, A_H1_EN, q);
        `CHK("h1 enable reset", 16'h0000, q)
        rd(1, A_H2_EN, q);
        `CHK("h2 enable reset", 16'h0000, q)
        // Each event sets only its own flag; all enables off
        foreach (rows[i]) begin
            wr(i[0], A_H1_FLG, 16'hffff);
            attach <= rows[i].att;
            pulse(rows[i].eng, 8'h00, rows[i].wk);
            rd(~i[0], A_H1_FLG, q);
            `CHK("row", rows[i].exp, q)
            `CHK("irq masked", 1'b0, irq_host1)
        end
        wr(0, A_H1_FLG, 16'hffff);
        rd(1, A_H1_FLG, q);
        `CHK("h1 status cleared", 16'h0000, q)
        // Reserved bits and host2 OTG pair stay zero
        wr(0, A_H1_EN, 16'hffff);
        rd(0, A_H1_EN, q);
        `CHK("h1 enable mask", M_H1, q)
        wr(1, A_H2_EN, 16'hffff);
        rd(1, A_H2_EN, q);
        `CHK("h2 enable mask", M_H2, q)
        pulse(8'h00, 8'h83, 2'b00);
        rd(0, A_H2_FLG, q);
        `CHK("h2 status otg", 16'h0001, q)
        `CHK("h2 irq", 1'b1, irq_host2)
        // Wakeups and a port B removal with all enables on
        attach <= 2'b01;
        pulse(8'h00, 8'h00, 2'b11);
        rd(0, A_H1_FLG, q);
        `CHK("h1 wake conn", 16'h00e8, q)
        `CHK("h1 wake irq", 1'b1, irq_host1)
        attach <= 2'b11;
        // Target address is write only and seven bits wide
        wr(0, A_H1_ADR, 16'h00ff);
        `CHK("h1 addr", 7'h7f, h1_dev_addr)
        rd(0, A_H1_ADR, q);
        `CHK("h1 addr read", 16'h0000, q)
        wr(1, A_H2_ADR, 16'h0055);
        `CHK("h2 addr", 7'h55, h2_dev_addr)
        // Both ports write one address in the same cycle: processor wins
        cpu_bus <= '{wr: 1'b1, rd: 1'b0, addr: A_H2_ADR, wdata: 16'h0011};
        hpi_bus <= '{wr: 1'b1, rd: 1'b0, addr: A_H2_ADR, wdata: 16'h0022};
        @(posedge mclk);
        cpu_bus <= '0;
        hpi_bus <= '0;
        @(posedge mclk);
        `CHK("addr collision", 7'h11, h2_dev_addr)
        wr(0, 16'hc09e, 16'hffff);
        rd(0, 16'hc09e, q);
        `CHK("unmapped", 16'h0000, q)
        // Done interrupt: raise, hold through zero write, clear, mask
        wr(0, A_H1_EN, 16'h0001);
        wr(0, A_H1_FLG, 16'hffff);
        pulse(8'h80, 8'h00, 2'b00);
        @(posedge mclk);
        `CHK("irq raised", 1'b1, irq_host1)
        wr(1, A_H1_FLG, 16'h0000);
        rd(0, A_H1_FLG, q);
        `CHK("zero write keeps", 16'h0001, q)
        `CHK("irq kept", 1'b1, irq_host1)
        wr(1, A_H1_FLG, 16'h0001);
        @(posedge mclk);
        `CHK("irq cleared", 1'b0, irq_host1)
        pulse(8'h80, 8'h00, 2'b00);
        wr(0, A_H1_EN, 16'h0000);
        @(posedge mclk);
        `CHK("irq disabled", 1'b0, irq_host1)
        // Clear and new event on the same edge: the event wins
        wr(0, A_H1_EN, 16'h0200);
        wr(0, A_H1_FLG, 16'hffff);
        cpu_bus <= '{wr: 1'b1, rd: 1'b0, addr: A_H1_FLG, wdata: 16'hffff};
        eng1 <= 8'h40;
        @(posedge mclk);
        cpu_bus <= '0;
        eng1 <= 8'h00;
        @(posedge mclk);
        rd(1, A_H1_FLG, q);
        `CHK("set beats clear", 16'h0200, q)
        `CHK("sof irq", 1'b1, irq_host1)
        // Second reset in mid-run drops everything
        reset_dut();
        `CHK("irq after reset", 1'b0, irq_host1)
        `CHK("addr after reset", 7'h00, h1_dev_addr)
        wrap_up();
    end
endmodule // usb_host_interrupt_status_test
